// [verilog/ffr2_pkg.sv]
// Package for the second fault flag register: offsets, bit positions, types
// Behaviour
// - The second fault register sits at address 0x0b and its fault bits are latched flags by default.
// - Bit 4 reports a common-electrode buffer undervoltage fault, latched or live by the latch-disable setting.
// - Bit 3 reports a common-electrode buffer overvoltage fault, latched or live by the latch-disable setting.
// - With latching on, a buffer fault bit reads 1 if the fault happened or persists, clears on read and sets again while the fault stays.
// - With latch-disable at 1, a buffer fault bit mirrors the present fault and reads 0 otherwise.
// - Bit 1 latches a thermal-shutdown event and sets again after a read while shutdown is still active.
// - The thermal-shutdown bit reads 0 with no shutdown since the last read and 1 while in shutdown.
// - Bit 0 is a read-only reset indicator with reset value 1, set by every power-on reset.
// - The reset indicator reads 1 only on the first read after power-on reset and 0 afterwards.
// - A set mask bit keeps its buffer fault from pulling the active-low fault output low.
package ffr2_pkg;
	localparam logic [7:0] FFR2_ADDR = 8'h0b;
	localparam int FFR2_UV_BIT = 4;
	localparam int FFR2_OV_BIT = 3;
	localparam int FFR2_TS_BIT = 1;
	localparam int FFR2_POR_BIT = 0;
	localparam logic [2:0] FFR2_FLAG_RST = 3'h0;
	localparam logic FFR2_POR_RST = 1'b1;

	// Live fault conditions from the analog monitors
	typedef struct packed {
		logic undervolt;
		logic overvolt;
		logic thermal;
	} ffr2_fault_t;

	// One register access from the serial interface
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ffr2_acc_t;
endpackage

// [verilog/ffr2_fault_flags.sv]
// Second fault flag register with clear-on-read and write-0-to-clear bits
`timescale 1ns/1ps
module ffr2_fault_flags (
	input wire logic mclk_i, // 200 MHz clock
	input wire logic rst_b_i, // Power-on reset, active low
	input wire ffr2_pkg::ffr2_fault_t fault_i, // Raw fault levels (async)
	input wire ffr2_pkg::ffr2_acc_t acc_i, // Register access strobes
	input wire logic latch_dis_i, // 1: buffer bits are live status
	input wire logic uv_mask_i, // common_undervolt_mask_bit
	input wire logic ov_mask_i, // common_overvolt_mask_bit
	output logic [7:0] rdata_o, // Read data, valid cycle after rd
	output logic buf_fault_req_o // Unmasked buffer fault, to fault pin
);
	ffr2_pkg::ffr2_fault_t sync1_q;
	ffr2_pkg::ffr2_fault_t sync1_d;
	ffr2_pkg::ffr2_fault_t sync2_q;
	ffr2_pkg::ffr2_fault_t sync2_d;
	logic uv_q;
	logic uv_d;
	logic ov_q;
	logic ov_d;
	logic ts_q;
	logic ts_d;
	logic por_q;
	logic por_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] view;
	logic hit_rd;
	logic hit_wr;
	logic seen_rd_q;
	logic seen_rd_d;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// Fault levels are asynchronous; only the second flop feeds logic
	always_comb begin
		sync1_d = fault_i;
		sync2_d = sync1_q;
	end

	assign hit_rd = acc_i.rd && acc_i.addr == ffr2_pkg::FFR2_ADDR;
	assign hit_wr = acc_i.wr && acc_i.addr == ffr2_pkg::FFR2_ADDR;

	always_comb begin
		view = 8'h00;
		view[ffr2_pkg::FFR2_UV_BIT] = latch_dis_i ?
			sync2_q.undervolt : uv_q;
		view[ffr2_pkg::FFR2_OV_BIT] = latch_dis_i ? sync2_q.overvolt : ov_q;
		view[ffr2_pkg::FFR2_TS_BIT] = ts_q;
		view[ffr2_pkg::FFR2_POR_BIT] = por_q;
	end

	// Set wins over clear so an event in the read cycle is not lost
	always_comb begin
		uv_d = uv_q;
		ov_d = ov_q;
		ts_d = ts_q;
		por_d = por_q;
		rdata_d = rdata_q;
		if (hit_rd) begin
			rdata_d = view;
			uv_d = 1'b0;
			ov_d = 1'b0;
			ts_d = 1'b0;
			por_d = 1'b0;
		end
		if (hit_wr) begin
			if (!acc_i.wdata[ffr2_pkg::FFR2_UV_BIT])
				uv_d = 1'b0;
			if (!acc_i.wdata[ffr2_pkg::FFR2_OV_BIT])
				ov_d = 1'b0;
			if (!acc_i.wdata[ffr2_pkg::FFR2_TS_BIT])
				ts_d = 1'b0;
		end
		// Latched copies track while latch-disabled, so switching mode is clean
		if (sync2_q.undervolt)
			uv_d = 1'b1;
		if (sync2_q.overvolt)
			ov_d = 1'b1;
		if (sync2_q.thermal)
			ts_d = 1'b1;
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{uv_q, ov_q, ts_q} <= ffr2_pkg::FFR2_FLAG_RST;
			por_q <= ffr2_pkg::FFR2_POR_RST;
			rdata_q <= 8'h00;
		end else begin
			uv_q <= uv_d;
			ov_q <= ov_d;
			ts_q <= ts_d;
			por_q <= por_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;
	assign buf_fault_req_o = (view[ffr2_pkg::FFR2_UV_BIT] && !uv_mask_i)
		|| (view[ffr2_pkg::FFR2_OV_BIT] && !ov_mask_i);

	// Checking aid only: remembers that a read hit was taken since reset
	always_comb begin
		seen_rd_d = seen_rd_q;
		if (hit_rd)
			seen_rd_d = 1'b1;
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			seen_rd_q <= 1'b0;
		else
			seen_rd_q <= seen_rd_d;
	end

	uv_set_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		sync2_q.undervolt |=> uv_q)
		else $error("undervolt flag not set by fault");

	ov_set_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		sync2_q.overvolt |=> ov_q)
		else $error("overvolt flag not set by fault");

	ts_set_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		sync2_q.thermal |=> ts_q)
		else $error("thermal flag not set by event");

	uv_live_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && latch_dis_i |=> rdata_o[ffr2_pkg::FFR2_UV_BIT] ==
			$past(sync2_q.undervolt))
		else $error("live undervolt bit wrong");

	ov_live_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && latch_dis_i |=> rdata_o[ffr2_pkg::FFR2_OV_BIT] ==
			$past(sync2_q.overvolt))
		else $error("live overvolt bit wrong");

	uv_latch_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && !latch_dis_i |=> rdata_o[ffr2_pkg::FFR2_UV_BIT] ==
			$past(uv_q))
		else $error("undervolt read wrong");

	ov_latch_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && !latch_dis_i |=> rdata_o[ffr2_pkg::FFR2_OV_BIT] ==
			$past(ov_q))
		else $error("overvolt read wrong");

	uv_cor_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && !sync2_q.undervolt |=> !uv_q)
		else $error("undervolt flag not cleared on read");

	ov_cor_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && !sync2_q.overvolt |=> !ov_q)
		else $error("overvolt flag not cleared on read");

	ts_cor_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && !sync2_q.thermal |=> !ts_q)
		else $error("thermal flag not cleared on read");

	ts_hold_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		ts_q && !hit_rd && !hit_wr |=> ts_q)
		else $error("thermal flag lost");

	ts_read_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd |=> rdata_o[ffr2_pkg::FFR2_TS_BIT] == $past(ts_q))
		else $error("thermal read wrong");

	por_first_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && !seen_rd_q |=> rdata_o[ffr2_pkg::FFR2_POR_BIT])
		else $error("reset indicator missing on first read");

	por_once_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd && seen_rd_q |=> !rdata_o[ffr2_pkg::FFR2_POR_BIT])
		else $error("reset indicator seen twice");

	por_up_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) |-> por_q)
		else $error("reset indicator clear after reset");

	por_hold_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		por_q && !hit_rd |=> por_q)
		else $error("reset indicator lost without read");

	wr_clr_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_wr && !acc_i.wdata[ffr2_pkg::FFR2_TS_BIT] &&
			!sync2_q.thermal |=> !ts_q)
		else $error("write zero did not clear thermal");

	uv_wr_clr_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_wr && !acc_i.wdata[ffr2_pkg::FFR2_UV_BIT] &&
			!sync2_q.undervolt |=> !uv_q)
		else $error("write zero did not clear undervolt");

	wr_keep_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_wr && !hit_rd && acc_i.wdata[ffr2_pkg::FFR2_TS_BIT] &&
			ts_q |=> ts_q)
		else $error("write one changed thermal");

	rdata_hold_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		!hit_rd |=> $stable(rdata_o))
		else $error("read data changed without read");

	unused_zero_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		hit_rd |=> rdata_o[7:5] == 3'h0 && !rdata_o[2])
		else $error("unused bit read as one");

	fault_mask_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		uv_mask_i && ov_mask_i |-> !buf_fault_req_o)
		else $error("masked fault reached output");

	uv_mask_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		uv_mask_i && latch_dis_i && !sync2_q.overvolt |->
			!buf_fault_req_o)
		else $error("masked undervolt reached output");

	req_live_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		latch_dis_i && !uv_mask_i && sync2_q.undervolt |->
			buf_fault_req_o)
		else $error("unmasked undervolt missing at output");
endmodule

// [dv/ffr2_host.sv]
// Serial host model issuing accesses to the fault register
`timescale 1ns/1ps
module ffr2_host (
	input wire logic mclk_i, // Clock
	output ffr2_pkg::ffr2_acc_t acc_o // Access strobes
);
	initial acc_o = '0;
	// One-cycle strobe, read or write, never both
	task automatic access(input logic r, input logic [7:0] a, d);
		@(posedge mclk_i);
		acc_o <= {r, ~r, a, d};
		@(posedge mclk_i);
		acc_o <= '0;
	endtask
endmodule

// [dv/ffr2_fault_flags_test.sv]
// Self-checking bench for the second fault flag register
`timescale 1ns/1ps
module ffr2_fault_flags_test;
	logic mclk_i = 0, rst_b_i = 0, ldis = 0, uvm = 0, ovm = 0, req;
	ffr2_pkg::ffr2_fault_t flt = '0;
	ffr2_pkg::ffr2_acc_t acc;
	logic [7:0] rd;
	int fails = 0, check_count = 0;
	ffr2_host i_ffr2_host (.mclk_i(mclk_i), .acc_o(acc));
	ffr2_fault_flags i_ffr2_fault_flags (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.fault_i(flt), .acc_i(acc), .latch_dis_i(ldis), .uv_mask_i(uvm),
		.ov_mask_i(ovm), .rdata_o(rd), .buf_fault_req_o(req));
	initial forever #2.5 mclk_i = ~mclk_i;
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(logic [7:0] e, logic [7:0] a = ffr2_pkg::FFR2_ADDR);
		i_ffr2_host.access(1'b1, a, 8'h00);
		@(negedge mclk_i);
		chk("rdata", e, rd);
	endtask
	// Two-flop synchroniser needs settling before a read
	task automatic setf(logic [2:0] f);
		@(posedge mclk_i);
		flt <= f;
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		finish_test;
	end
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rdc(8'h00, 8'h0a);
		rdc(8'h01);
		rdc(8'h00);
		$display("test reset done");
		setf(3'h5);
		setf(3'h0);
		i_ffr2_host.access(1'b0, ffr2_pkg::FFR2_ADDR, 8'hef);
		rdc(8'h02);
		rdc(8'h00);
		setf(3'h5);
		setf(3'h0);
		i_ffr2_host.access(1'b0, ffr2_pkg::FFR2_ADDR, 8'hfd);
		rdc(8'h10);
		$display("test write done");
		@(posedge mclk_i);
		ovm <= 1'b1;
		setf(3'h3);
		chk("req", 8'h00, {7'h0, req});
		rdc(8'h0a);
		rdc(8'h0a);
		setf(3'h0);
		rdc(8'h0a);
		rdc(8'h00);
		$display("test latch done");
		@(posedge mclk_i);
		ldis <= 1'b1;
		setf(3'h4);
		chk("req", 8'h01, {7'h0, req});
		@(posedge mclk_i);
		uvm <= 1'b1;
		@(negedge mclk_i);
		chk("req", 8'h00, {7'h0, req});
		rdc(8'h10);
		setf(3'h0);
		rdc(8'h00);
		$display("test live done");
		finish_test;
	end
endmodule
